// [shared/vntrp_pkg.sv]
// Purpose: Constants and types shared by both ends of the token request port
// Assumes: One clock, synchronous active-high reset
// Notes: Widths and reset values used by both ends and the checker
package vntrp_pkg;
  localparam int NUM_VN      = 4;
  localparam int PRIO_W      = 4;
  localparam int VNID_W      = 4;
  localparam int CH_WR_ADDR  = 0;
  localparam int CH_WR_DATA  = 1;
  localparam int CH_RD_ADDR  = 2;
  localparam int NUM_CH      = 3;
  localparam logic [3:0] THRESH_RST = 4'h0;
  localparam logic [7:0] CREDIT_RST = 8'h04;
  localparam logic [7:0] CREDIT_MAX = 8'hFF;
  typedef logic [PRIO_W-1:0] vntrp_prio_t;
  typedef logic [VNID_W-1:0] vntrp_vnid_t;
endpackage

// [shared/vntrp_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Token request link between master and slave ends; requests, grants and priorities per network, thresholds and network ids shared
interface vntrp_if;
  logic [vntrp_pkg::NUM_VN-1:0] wr_addr_token_req;
  logic [vntrp_pkg::NUM_VN-1:0] wr_addr_token_grant;
  vntrp_pkg::vntrp_prio_t       wr_addr_token_priority [vntrp_pkg::NUM_VN];
  logic [vntrp_pkg::NUM_VN-1:0] wr_data_token_req;
  logic [vntrp_pkg::NUM_VN-1:0] wr_data_token_grant;
  logic [vntrp_pkg::NUM_VN-1:0] rd_addr_token_req;
  logic [vntrp_pkg::NUM_VN-1:0] rd_addr_token_grant;
  vntrp_pkg::vntrp_prio_t       rd_addr_token_priority [vntrp_pkg::NUM_VN];
  vntrp_pkg::vntrp_prio_t       wr_addr_threshold;
  vntrp_pkg::vntrp_prio_t       rd_addr_threshold;
  vntrp_pkg::vntrp_vnid_t       wr_addr_network_id;
  vntrp_pkg::vntrp_vnid_t       wr_data_network_id;
  vntrp_pkg::vntrp_vnid_t       rd_addr_network_id;
  modport master (
    output wr_addr_token_req, wr_addr_token_priority, wr_data_token_req,
    output rd_addr_token_req, rd_addr_token_priority,
    output wr_addr_network_id, wr_data_network_id, rd_addr_network_id,
    input  wr_addr_token_grant, wr_data_token_grant, rd_addr_token_grant,
    input  wr_addr_threshold, rd_addr_threshold
  );
  modport slave (
    input  wr_addr_token_req, wr_addr_token_priority, wr_data_token_req,
    input  rd_addr_token_req, rd_addr_token_priority,
    input  wr_addr_network_id, wr_data_network_id, rd_addr_network_id,
    output wr_addr_token_grant, wr_data_token_grant, rd_addr_token_grant,
    output wr_addr_threshold, rd_addr_threshold
  );
endinterface
`default_nettype wire

// [logic/vntrp_master.sv]
// Purpose: Master end: raises token requests per network and channel
// Assumes: Same clock as the slave end; user pulses are one cycle
// Notes: One pending token per channel and network; priority captured with it on wa and ra
`timescale 1ns/10ps
`default_nettype none
module vntrp_master (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  // User side: one-cycle asks per network
  input  wire logic [3:0]             wa_ask_i,
  input  wire logic [3:0]             wd_ask_i,
  input  wire logic [3:0]             ra_ask_i,
  input  wire logic [15:0]            wa_prio_i,
  input  wire logic [15:0]            ra_prio_i,
  output logic      [3:0]             wa_busy_o,
  output logic      [3:0]             wd_busy_o,
  output logic      [3:0]             ra_busy_o,
  output logic      [3:0]             wa_done_o,
  output logic      [3:0]             wd_done_o,
  output logic      [3:0]             ra_done_o,
  // Link
  vntrp_if.master                     link
);
  typedef struct packed {
    logic [3:0]  wa_pend;
    logic [3:0]  wd_pend;
    logic [3:0]  ra_pend;
    logic [15:0] wa_prio;
    logic [15:0] ra_prio;
    logic [3:0]  wa_done;
    logic [3:0]  wd_done;
    logic [3:0]  ra_done;
    logic [3:0]  wa_vnid;
    logic [3:0]  wd_vnid;
    logic [3:0]  ra_vnid;
  } vntrp_mst_st_t;

  vntrp_mst_st_t st_reg;
  vntrp_mst_st_t st_next;
  logic [3:0] wa_fire;
  logic [3:0] wd_fire;
  logic [3:0] ra_fire;
  logic [3:0] wa_ok;
  logic [3:0] ra_ok;

  genvar g;
  generate
    for (g = 0; g < vntrp_pkg::NUM_VN; g++) begin : g_vn
      // Requests below the threshold are held back, not dropped
      assign wa_ok[g] = st_reg.wa_prio[g*4 +: 4] >= link.wr_addr_threshold;
      assign ra_ok[g] = st_reg.ra_prio[g*4 +: 4] >= link.rd_addr_threshold;
      assign link.wr_addr_token_req[g] = st_reg.wa_pend[g] & wa_ok[g];
      assign link.rd_addr_token_req[g] = st_reg.ra_pend[g] & ra_ok[g];
      assign link.wr_data_token_req[g] = st_reg.wd_pend[g];
      assign link.wr_addr_token_priority[g] = st_reg.wa_prio[g*4 +: 4];
      assign link.rd_addr_token_priority[g] = st_reg.ra_prio[g*4 +: 4];
      assign wa_fire[g] = link.wr_addr_token_req[g] & link.wr_addr_token_grant[g];
      assign wd_fire[g] = link.wr_data_token_req[g] & link.wr_data_token_grant[g];
      assign ra_fire[g] = link.rd_addr_token_req[g] & link.rd_addr_token_grant[g];
    end
  endgenerate

  assign link.wr_addr_network_id = st_reg.wa_vnid;
  assign link.wr_data_network_id = st_reg.wd_vnid;
  assign link.rd_addr_network_id = st_reg.ra_vnid;

  function automatic logic [3:0] lowest_idx(input logic [3:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.wa_done = wa_fire;
    st_next.wd_done = wd_fire;
    st_next.ra_done = ra_fire;
    for (int i = 0; i < vntrp_pkg::NUM_VN; i++) begin
      // New asks are only taken when idle, so priority stays steady
      if (!st_reg.wa_pend[i] && wa_ask_i[i]) begin
        st_next.wa_pend[i] = 1'b1;
        st_next.wa_prio[i*4 +: 4] = wa_prio_i[i*4 +: 4];
      end else if (wa_fire[i]) begin
        st_next.wa_pend[i] = 1'b0;
      end
      if (!st_reg.wd_pend[i] && wd_ask_i[i]) begin
        st_next.wd_pend[i] = 1'b1;
      end else if (wd_fire[i]) begin
        st_next.wd_pend[i] = 1'b0;
      end
      if (!st_reg.ra_pend[i] && ra_ask_i[i]) begin
        st_next.ra_pend[i] = 1'b1;
        st_next.ra_prio[i*4 +: 4] = ra_prio_i[i*4 +: 4];
      end else if (ra_fire[i]) begin
        st_next.ra_pend[i] = 1'b0;
      end
    end
    st_next.wa_vnid = lowest_idx(st_next.wa_pend);
    st_next.wd_vnid = lowest_idx(st_next.wd_pend);
    st_next.ra_vnid = lowest_idx(st_next.ra_pend);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wa_busy_o = st_reg.wa_pend;
  assign wd_busy_o = st_reg.wd_pend;
  assign ra_busy_o = st_reg.ra_pend;
  assign wa_done_o = st_reg.wa_done;
  assign wd_done_o = st_reg.wd_done;
  assign ra_done_o = st_reg.ra_done;
endmodule // vntrp_master
`default_nettype wire

// [logic/vntrp_slave.sv]
// Purpose: Slave end: grants token requests from a credit pool per channel and network
// Assumes: Same clock as the master end
// Notes: Grant is a registered level per network while credits remain
`timescale 1ns/10ps
`default_nettype none
module vntrp_slave (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // User side: thresholds and returned credits
  input  wire logic [3:0]  wa_thresh_i,
  input  wire logic [3:0]  ra_thresh_i,
  input  wire logic [3:0]  wa_credit_ret_i,
  input  wire logic [3:0]  wd_credit_ret_i,
  input  wire logic [3:0]  ra_credit_ret_i,
  output logic      [3:0]  wa_taken_o,
  output logic      [3:0]  wd_taken_o,
  output logic      [3:0]  ra_taken_o,
  // Link
  vntrp_if.slave           link
);
  typedef struct packed {
    logic [3:0][7:0] wa_cred;
    logic [3:0][7:0] wd_cred;
    logic [3:0][7:0] ra_cred;
    logic [3:0]      wa_gnt;
    logic [3:0]      wd_gnt;
    logic [3:0]      ra_gnt;
    logic [3:0]      wa_tk;
    logic [3:0]      wd_tk;
    logic [3:0]      ra_tk;
    logic [3:0]      wa_th;
    logic [3:0]      ra_th;
  } vntrp_slv_st_t;

  vntrp_slv_st_t st_reg;
  vntrp_slv_st_t st_next;
  logic [3:0] wa_fire;
  logic [3:0] wd_fire;
  logic [3:0] ra_fire;

  assign wa_fire = link.wr_addr_token_req & st_reg.wa_gnt;
  assign wd_fire = link.wr_data_token_req & st_reg.wd_gnt;
  assign ra_fire = link.rd_addr_token_req & st_reg.ra_gnt;

  function automatic logic [7:0] upd(input logic [7:0] c, input logic take,
                                     input logic ret);
    logic [7:0] r;
    r = c;
    if (take && !ret) begin
      r = c - 8'h01;
    end else if (ret && !take && c != vntrp_pkg::CREDIT_MAX) begin
      r = c + 8'h01;
    end
    return r;
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.wa_th = wa_thresh_i;
    st_next.ra_th = ra_thresh_i;
    st_next.wa_tk = wa_fire;
    st_next.wd_tk = wd_fire;
    st_next.ra_tk = ra_fire;
    for (int i = 0; i < vntrp_pkg::NUM_VN; i++) begin
      st_next.wa_cred[i] = upd(st_reg.wa_cred[i], wa_fire[i], wa_credit_ret_i[i]);
      st_next.wd_cred[i] = upd(st_reg.wd_cred[i], wd_fire[i], wd_credit_ret_i[i]);
      st_next.ra_cred[i] = upd(st_reg.ra_cred[i], ra_fire[i], ra_credit_ret_i[i]);
      st_next.wa_gnt[i] = st_next.wa_cred[i] != 8'h00;
      st_next.wd_gnt[i] = st_next.wd_cred[i] != 8'h00;
      st_next.ra_gnt[i] = st_next.ra_cred[i] != 8'h00;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      for (int i = 0; i < vntrp_pkg::NUM_VN; i++) begin
        st_reg.wa_cred[i] <= vntrp_pkg::CREDIT_RST;
        st_reg.wd_cred[i] <= vntrp_pkg::CREDIT_RST;
        st_reg.ra_cred[i] <= vntrp_pkg::CREDIT_RST;
      end
      st_reg.wa_th <= vntrp_pkg::THRESH_RST;
      st_reg.ra_th <= vntrp_pkg::THRESH_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.wr_addr_token_grant = st_reg.wa_gnt;
  assign link.wr_data_token_grant = st_reg.wd_gnt;
  assign link.rd_addr_token_grant = st_reg.ra_gnt;
  assign link.wr_addr_threshold   = st_reg.wa_th;
  assign link.rd_addr_threshold   = st_reg.ra_th;
  assign wa_taken_o = st_reg.wa_tk;
  assign wd_taken_o = st_reg.wd_tk;
  assign ra_taken_o = st_reg.ra_tk;
endmodule // vntrp_slave
`default_nettype wire

// [verification/vntrp_monitor.sv]
// Purpose: Watches the token link between both ends
// Assumes: One clock, sync reset active high
// Notes: One set of checks per network
`timescale 1ns/10ps
`default_nettype none
module vntrp_monitor (
  // Clock and reset
  input wire logic                   core_clk_i,
  input wire logic                   rst_i,
  // Link
  input wire logic [3:0]             wr_addr_token_req,
  input wire logic [3:0]             wr_addr_token_grant,
  input wire logic [3:0]             wr_data_token_req,
  input wire logic [3:0]             wr_data_token_grant,
  input wire logic [3:0]             rd_addr_token_req,
  input wire logic [3:0]             rd_addr_token_grant,
  input wire vntrp_pkg::vntrp_prio_t wr_addr_token_priority [4],
  input wire vntrp_pkg::vntrp_prio_t rd_addr_token_priority [4],
  input wire vntrp_pkg::vntrp_prio_t wr_addr_threshold,
  input wire vntrp_pkg::vntrp_prio_t rd_addr_threshold,
  input wire vntrp_pkg::vntrp_vnid_t wr_data_network_id
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  for (genvar n = 0; n < 4; n++) begin : g_vn
    property p_wa_hold;
      wr_addr_token_req[n] && !wr_addr_token_grant[n] |=>
        wr_addr_token_req[n] && $stable(wr_addr_token_priority[n]);
    endproperty
    a_wa_hold: assert property (p_wa_hold) else $error("wa request dropped");
    property p_wd_hold;
      wr_data_token_req[n] && !wr_data_token_grant[n] |=> wr_data_token_req[n];
    endproperty
    a_wd_hold: assert property (p_wd_hold) else $error("wd request dropped");
    property p_ra_hold;
      rd_addr_token_req[n] && !rd_addr_token_grant[n] |=>
        rd_addr_token_req[n] && $stable(rd_addr_token_priority[n]);
    endproperty
    a_ra_hold: assert property (p_ra_hold) else $error("ra request dropped");
    property p_wa_stall;
      wr_addr_token_req[n] |-> wr_addr_token_priority[n] >= wr_addr_threshold;
    endproperty
    a_wa_stall: assert property (p_wa_stall) else $error("wa below threshold");
    property p_ra_stall;
      rd_addr_token_req[n] |-> rd_addr_token_priority[n] >= rd_addr_threshold;
    endproperty
    a_ra_stall: assert property (p_ra_stall) else $error("ra below threshold");
    property p_wa_once;
      wr_addr_token_req[n] && wr_addr_token_grant[n] |=> !wr_addr_token_req[n];
    endproperty
    a_wa_once: assert property (p_wa_once) else $error("wa token sent twice");
    property p_ra_once;
      rd_addr_token_req[n] && rd_addr_token_grant[n] |=> !rd_addr_token_req[n];
    endproperty
    a_ra_once: assert property (p_ra_once) else $error("ra token sent twice");
    property p_wd_once;
      wr_data_token_req[n] && wr_data_token_grant[n] |=> !wr_data_token_req[n];
    endproperty
    a_wd_once: assert property (p_wd_once) else $error("wd token sent twice");
    property p_wd_id;
      wr_data_token_req == (4'h1 << n) |-> wr_data_network_id == n;
    endproperty
    a_wd_id: assert property (p_wd_id) else $error("wrong network id");
  end
endmodule // vntrp_monitor
`default_nettype wire

// [verification/virtual_network_token_request_port_bench.sv]
// Purpose: Drives both ends and checks user-side results
// Assumes: Credits 4 per channel and network after reset
// Notes: Channel index 0 wa, 1 wd, 2 ra
`timescale 1ns/10ps
`default_nettype none
module virtual_network_token_request_port_bench;
  logic       core_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [3:0] ask [3] = '{default: 4'h0};
  logic [3:0] ret [3] = '{default: 4'h0};
  logic [3:0] thr [3] = '{default: 4'h0};
  logic [15:0] pri [3] = '{default: 16'h0};
  wire  [3:0] busy [3];
  wire  [3:0] done [3];
  wire  [3:0] tkn [3];
  int         fails = 0;
  int         n_checks = 0;
  vntrp_if vntrp_if_i ();
  vntrp_master vntrp_master_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .wa_ask_i(ask[0]),
    .wd_ask_i(ask[1]), .ra_ask_i(ask[2]), .wa_prio_i(pri[0]), .ra_prio_i(pri[2]),
    .wa_busy_o(busy[0]), .wd_busy_o(busy[1]), .ra_busy_o(busy[2]), .wa_done_o(done[0]),
    .wd_done_o(done[1]), .ra_done_o(done[2]), .link(vntrp_if_i));
  vntrp_slave vntrp_slave_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .wa_thresh_i(thr[0]),
    .ra_thresh_i(thr[2]), .wa_credit_ret_i(ret[0]), .wd_credit_ret_i(ret[1]),
    .ra_credit_ret_i(ret[2]), .wa_taken_o(tkn[0]), .wd_taken_o(tkn[1]), .ra_taken_o(tkn[2]),
    .link(vntrp_if_i));
  vntrp_monitor vntrp_monitor_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .wr_addr_token_req(vntrp_if_i.wr_addr_token_req),
    .wr_addr_token_grant(vntrp_if_i.wr_addr_token_grant),
    .wr_data_token_req(vntrp_if_i.wr_data_token_req),
    .wr_data_token_grant(vntrp_if_i.wr_data_token_grant),
    .rd_addr_token_req(vntrp_if_i.rd_addr_token_req),
    .rd_addr_token_grant(vntrp_if_i.rd_addr_token_grant),
    .wr_addr_token_priority(vntrp_if_i.wr_addr_token_priority),
    .rd_addr_token_priority(vntrp_if_i.rd_addr_token_priority),
    .wr_addr_threshold(vntrp_if_i.wr_addr_threshold),
    .rd_addr_threshold(vntrp_if_i.rd_addr_threshold),
    .wr_data_network_id(vntrp_if_i.wr_data_network_id));
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      fails++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One-cycle ask, then look for done and taken together
  task automatic xfer(input int c, input int n, input logic [3:0] p, input bit exp);
    bit got;
    got = 1'b0;
    @(posedge core_clk_i);
    ask[c][n] <= 1'b1;
    pri[c][n*4+:4] <= p;
    @(posedge core_clk_i);
    ask[c][n] <= 1'b0;
    repeat (4) begin
      tick(1);
      if (done[c][n] === 1'b1) begin
        got = 1'b1;
        chk(tkn[c][n] === 1'b1, "taken missing");
      end
    end
    chk(got == exp, "done wrong");
  endtask
  task automatic t_reset();
    tick(2);
    for (int c = 0; c < 3; c++) chk(busy[c] === 4'h0, "busy after reset");
    chk(vntrp_if_i.wr_addr_token_grant === 4'hF, "wa grant");
    chk(vntrp_if_i.wr_data_token_grant === 4'hF, "wd grant");
    chk(vntrp_if_i.rd_addr_token_grant === 4'hF, "ra grant");
    $display("reset test done");
  endtask
  task automatic t_each();
    for (int c = 0; c < 3; c++)
      for (int n = 0; n < 4; n++) xfer(c, n, 4'(n + 5), 1'b1);
    $display("each channel test done");
  endtask
  task automatic t_stall(input int c);
    @(posedge core_clk_i);
    thr[c] <= 4'h8;
    tick(3);
    xfer(c, 1, 4'h7, 1'b0);
    chk(busy[c][1] === 1'b1, "stalled ask lost");
    xfer(c, 2, 4'h8, 1'b1);
    @(posedge core_clk_i);
    thr[c] <= 4'h0;
    tick(4);
    chk(busy[c][1] === 1'b0, "stall not released");
    $display("stall test done");
  endtask
  task automatic t_credit();
    for (int k = 0; k < 3; k++) xfer(1, 3, 4'h0, 1'b1);
    xfer(1, 3, 4'h0, 1'b0);
    xfer(1, 3, 4'h0, 1'b0);
    @(posedge core_clk_i);
    ret[1][3] <= 1'b1;
    @(posedge core_clk_i);
    ret[1][3] <= 1'b0;
    tick(5);
    chk(busy[1][3] === 1'b0, "credit return");
    $display("credit test done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_each();
    t_stall(0);
    t_stall(2);
    t_credit();
    give_verdict();
  end
  initial begin
    #(25 * 2000);
    fails++;
    give_verdict();
  end
endmodule // virtual_network_token_request_port_bench
`default_nettype wire
